// >>> hdl/irq_ctrl_pkg.sv
// Constants and carrier types for the prioritized interrupt latch controller.
// Assumes a CPU core on one clock that issues special-function register accesses.
package irq_ctrl_pkg;

    // ----------------------------------------
    // Special-function register addresses
    // ----------------------------------------
    localparam logic [15:0] ADDR_ENABLE_EXT = 16'h002C;
    localparam logic [15:0] ADDR_LATCH_EXT = 16'h002E;
    localparam logic [15:0] ADDR_ENABLE_LOW = 16'h003A;
    localparam logic [15:0] ADDR_ENABLE_HIGH = 16'h003B;
    localparam logic [15:0] ADDR_LATCH_LOW = 16'h003C;
    localparam logic [15:0] ADDR_LATCH_HIGH = 16'h003D;
    localparam int IMF_BIT = 0;

    // ----------------------------------------
    // Source numbering and vectors
    // ----------------------------------------
    localparam int SRC_FIRST = 2;
    localparam int SRC_LAST = 23;
    localparam int SRC_MASK_FIRST = 4;
    localparam int SRC_BANK1_FIRST = 16;
    localparam logic [4:0] SEL_TRAP = 5'h01;
    localparam logic [4:0] SEL_ADDR_TRAP = 5'h02;
    localparam logic [4:0] SEL_WATCHDOG = 5'h03;
    localparam logic [4:0] SEL_EXT_ZERO = 5'h04;
    localparam logic [4:0] SEL_BANK1 = 5'h10;
    localparam logic [15:0] VEC_RESET = 16'hFFFE;
    localparam logic [15:0] VEC_TRAP = 16'hFFFC;
    localparam logic [15:0] VEC_ADDR_TRAP = 16'hFFFA;
    localparam logic [15:0] VEC_WATCHDOG = 16'hFFF8;
    localparam logic [15:0] VEC_BANK0_TOP = 16'hFFF6;
    localparam logic [15:0] VEC_BANK1_TOP = 16'hFFBE;

    // ----------------------------------------
    // Reset values and timing
    // ----------------------------------------
    localparam logic [23:2] LATCH_RESET = 22'h000000;
    localparam logic [23:4] ENABLE_RESET = 20'h00000;
    localparam int CLKS_PER_MACHINE_CYCLE = 4;
    localparam int ACCEPT_MACHINE_CYCLES = 8;
    localparam int ACCEPT_CLKS = ACCEPT_MACHINE_CYCLES * CLKS_PER_MACHINE_CYCLE;
    localparam logic [4:0] ACCEPT_LAST_CNT = 5'(ACCEPT_CLKS - 2);
    localparam logic [4:0] PUSH_HIGH_CNT = 5'h03;
    localparam logic [4:0] PUSH_LOW_CNT = 5'h07;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ACCEPT = 2'b01,
        ST_FINISH = 2'b11
    } accept_state_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [15:0] addr;
        logic [7:0] wdata;
    } sfr_req_t;

endpackage

// >>> hdl/irq_latch_ctrl.sv
// Interrupt latches, enables, priority select and acceptance sequencer.
// Assumes the CPU core pulses instr_boundary between instructions and
// performs stack writes and the vector jump when strobed.
`timescale 1ns/1ps
`default_nettype none

module irq_latch_ctrl
    import irq_ctrl_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire sfr_req_t sfr,
    output logic [7:0] sfr_rdata,
    input wire logic [23:2] src_req,
    input wire logic software_trap,
    input wire logic illegal_opcode_trap,
    input wire logic ext_zero_pin_enable,
    input wire logic trap_action_select,
    input wire logic watchdog_action_select,
    input wire logic instr_boundary,
    input wire logic [15:0] cpu_pc,
    input wire logic [6:0] cpu_flags,
    input wire logic return_irq,
    input wire logic restored_imf,
    output logic irq_pending,
    output logic busy,
    output logic push_strobe,
    output logic [7:0] push_data,
    output logic sp_dec3,
    output logic vector_load,
    output logic [15:0] vector,
    output logic [4:0] accepted_source,
    output logic master_irq_enable_flag
);

    // ----------------------------------------
    // Latches and enables
    // ----------------------------------------
    logic [23:2] request_latch;
    logic [23:2] next_request_latch;
    logic [23:4] source_enable_flag;
    logic [23:4] next_source_enable_flag;
    logic next_imf;
    logic [7:0] next_sfr_rdata;
    logic [23:2] set_vec;
    logic [23:2] wr_clear;
    logic [23:2] eligible;
    logic [4:0] sel;
    logic trap_now;
    logic accept_go;
    accept_state_t state;
    accept_state_t next_state;

    // Address trap and watchdog only latch when routed as interrupts
    assign set_vec = {src_req[23:4], src_req[3] & ~watchdog_action_select,
        src_req[2] & ~trap_action_select};

    // Per-bit write-zero clear decode
    genvar gi;
    generate
        for (gi = SRC_FIRST; gi <= SRC_LAST; gi++)
        begin : g_clr
            localparam logic [15:0] BYTE_ADDR = (gi < 8) ? ADDR_LATCH_LOW :
                (gi < 16) ? ADDR_LATCH_HIGH : ADDR_LATCH_EXT;
            assign wr_clear[gi] = sfr.wr && sfr.addr == BYTE_ADDR
                && !sfr.wdata[gi % 8];
        end
    endgenerate

    // Eligibility: non-maskable always, maskable gated by master and own enable
    assign eligible = {request_latch[23:5] & source_enable_flag[23:5]
            & {19{master_irq_enable_flag}},
        request_latch[4] & source_enable_flag[4] & master_irq_enable_flag
            & ext_zero_pin_enable, request_latch[3:2]};

    assign trap_now = software_trap | illegal_opcode_trap;

    always_comb
    begin
        sel = 5'h00;
        for (int i = SRC_LAST; i >= SRC_FIRST; i--)
        begin
            if (eligible[i])
            begin
                sel = 5'(i);
            end
        end
        if (trap_now)
        begin
            sel = SEL_TRAP;
        end
    end

    assign irq_pending = (sel != 5'h00);
    assign accept_go = instr_boundary && state == ST_IDLE && irq_pending;

    function automatic logic [15:0] vector_of(input logic [4:0] idx);
        if (idx == SEL_TRAP)
        begin
            return VEC_TRAP;
        end
        else if (idx == SEL_ADDR_TRAP)
        begin
            return VEC_ADDR_TRAP;
        end
        else if (idx == SEL_WATCHDOG)
        begin
            return VEC_WATCHDOG;
        end
        else if (idx < SEL_BANK1)
        begin
            return VEC_BANK0_TOP - {10'h000, idx - SEL_EXT_ZERO, 1'b0};
        end
        else
        begin
            return VEC_BANK1_TOP - {10'h000, idx - SEL_BANK1, 1'b0};
        end
    endfunction

    always_comb
    begin
        // Set wins over any clear so a request in the clearing cycle survives
        next_request_latch = (request_latch & ~wr_clear) | set_vec;
        if (accept_go && sel != SEL_TRAP)
        begin
            next_request_latch[sel] = set_vec[sel];
        end
        next_source_enable_flag = source_enable_flag;
        next_imf = master_irq_enable_flag;
        if (sfr.wr && sfr.addr == ADDR_ENABLE_LOW)
        begin
            next_source_enable_flag[7:4] = sfr.wdata[7:4];
            next_imf = sfr.wdata[IMF_BIT];
        end
        if (sfr.wr && sfr.addr == ADDR_ENABLE_HIGH)
        begin
            next_source_enable_flag[15:8] = sfr.wdata;
        end
        if (sfr.wr && sfr.addr == ADDR_ENABLE_EXT)
        begin
            next_source_enable_flag[23:16] = sfr.wdata;
        end
        if (return_irq)
        begin
            next_imf = restored_imf;
        end
        if (accept_go)
        begin
            next_imf = 1'b0;
        end
        next_sfr_rdata = 8'h00;
        if (sfr.rd)
        begin
            case (sfr.addr)
                ADDR_LATCH_LOW: next_sfr_rdata = {request_latch[7:2], 2'b00};
                ADDR_LATCH_HIGH: next_sfr_rdata = request_latch[15:8];
                ADDR_LATCH_EXT: next_sfr_rdata = request_latch[23:16];
                ADDR_ENABLE_LOW: next_sfr_rdata = {source_enable_flag[7:4], 3'b000,
                    master_irq_enable_flag};
                ADDR_ENABLE_HIGH: next_sfr_rdata = source_enable_flag[15:8];
                ADDR_ENABLE_EXT: next_sfr_rdata = source_enable_flag[23:16];
                default: next_sfr_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            request_latch <= LATCH_RESET;
            source_enable_flag <= ENABLE_RESET;
            master_irq_enable_flag <= 1'b0;
            sfr_rdata <= 8'h00;
        end
        else
        begin
            request_latch <= next_request_latch;
            source_enable_flag <= next_source_enable_flag;
            master_irq_enable_flag <= next_imf;
            sfr_rdata <= next_sfr_rdata;
        end
    end

    // ----------------------------------------
    // Acceptance sequencer
    // ----------------------------------------
    logic [4:0] cnt;
    logic [4:0] next_cnt;
    logic [7:0] pc_high_save;
    logic [7:0] next_pc_high_save;
    logic [7:0] pc_low_save;
    logic [7:0] next_pc_low_save;
    logic next_push_strobe;
    logic [7:0] next_push_data;
    logic next_sp_dec3;
    logic [15:0] next_vector;
    logic [4:0] next_accepted_source;

    always_comb
    begin
        next_state = state;
        next_cnt = cnt;
        next_pc_high_save = pc_high_save;
        next_pc_low_save = pc_low_save;
        next_push_strobe = 1'b0;
        next_push_data = push_data;
        next_sp_dec3 = 1'b0;
        next_vector = vector;
        next_accepted_source = accepted_source;
        case (state)
            ST_IDLE:
            begin
                if (accept_go)
                begin
                    // Status word carries the master enable as it was before acceptance
                    next_state = ST_ACCEPT;
                    next_cnt = 5'h00;
                    next_push_strobe = 1'b1;
                    next_push_data = {cpu_flags, master_irq_enable_flag};
                    // Both PC bytes captured at once so they belong to one instruction
                    next_pc_high_save = cpu_pc[15:8];
                    next_pc_low_save = cpu_pc[7:0];
                    next_vector = vector_of(sel);
                    next_accepted_source = sel;
                end
            end
            ST_ACCEPT:
            begin
                next_cnt = cnt + 5'h01;
                if (cnt == PUSH_HIGH_CNT)
                begin
                    next_push_strobe = 1'b1;
                    next_push_data = pc_high_save;
                end
                if (cnt == PUSH_LOW_CNT)
                begin
                    next_push_strobe = 1'b1;
                    next_push_data = pc_low_save;
                    next_sp_dec3 = 1'b1;
                end
                if (cnt == ACCEPT_LAST_CNT)
                begin
                    next_state = ST_FINISH;
                end
            end
            ST_FINISH: next_state = ST_IDLE;
            default: next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state <= ST_IDLE;
            cnt <= 5'h00;
            pc_high_save <= 8'h00;
            pc_low_save <= 8'h00;
            push_strobe <= 1'b0;
            push_data <= 8'h00;
            sp_dec3 <= 1'b0;
            vector <= VEC_RESET;
            accepted_source <= 5'h00;
        end
        else
        begin
            state <= next_state;
            cnt <= next_cnt;
            pc_high_save <= next_pc_high_save;
            pc_low_save <= next_pc_low_save;
            push_strobe <= next_push_strobe;
            push_data <= next_push_data;
            sp_dec3 <= next_sp_dec3;
            vector <= next_vector;
            accepted_source <= next_accepted_source;
        end
    end

    assign busy = (state != ST_IDLE);
    assign vector_load = (state == ST_FINISH);

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    property p_clear_on_accept;
        accept_go && sel != SEL_TRAP && !set_vec[sel] |=> !request_latch[$past(sel)];
    endproperty
    a_clear_on_accept: assert property (p_clear_on_accept) else $error("latch kept");

    property p_no_sw_set;
        ((request_latch & ~$past(request_latch)) & ~$past(set_vec)) == 22'h000000;
    endproperty
    a_no_sw_set: assert property (p_no_sw_set) else $error("latch set without request");

    property p_mask_gate;
        accept_go && sel >= SEL_EXT_ZERO |-> master_irq_enable_flag
            && source_enable_flag[sel];
    endproperty
    a_mask_gate: assert property (p_mask_gate) else $error("masked source taken");

    property p_imf_drop;
        accept_go |=> !master_irq_enable_flag [*2];
    endproperty
    a_imf_drop: assert property (p_imf_drop) else $error("master enable kept");

    property p_push_seq;
        accept_go |=> push_strobe ##4 push_strobe ##4 (push_strobe && sp_dec3);
    endproperty
    a_push_seq: assert property (p_push_seq) else $error("push sequence wrong");

    property p_accept_time;
        accept_go |-> ##32 vector_load;
    endproperty
    a_accept_time: assert property (p_accept_time) else $error("accept length wrong");

    property p_bank1_vec;
        accept_go && sel == SEL_BANK1 |-> ##32 (vector == 16'hFFBE);
    endproperty
    a_bank1_vec: assert property (p_bank1_vec) else $error("bank1 vector wrong");

    property p_wdt_vec;
        accept_go && sel == SEL_WATCHDOG |=> vector == 16'hFFF8;
    endproperty
    a_wdt_vec: assert property (p_wdt_vec) else $error("watchdog vector wrong");

    property p_priority;
        accept_go && sel != SEL_TRAP |-> (eligible & ((22'h000001 << (sel - 5'h02))
            - 22'h000001)) == 22'h000000;
    endproperty
    a_priority: assert property (p_priority) else $error("lower priority taken");

    property p_return_from_maskable;
        return_irq && !accept_go |=> master_irq_enable_flag == $past(restored_imf);
    endproperty
    a_return_from_maskable: assert property (p_return_from_maskable) else $error("return reload wrong");

    property p_read_low;
        sfr.rd && sfr.addr == ADDR_LATCH_LOW |=> sfr_rdata == {$past(request_latch[7:2]), 2'b00};
    endproperty
    a_read_low: assert property (p_read_low) else $error("latch readback wrong");

    c_maskable: cover property (accept_go && sel >= SEL_EXT_ZERO);
    c_nonmask: cover property (accept_go && sel == SEL_ADDR_TRAP);
    c_trap: cover property (accept_go && sel == SEL_TRAP);
    c_return_from_maskable: cover property (return_irq ##1 master_irq_enable_flag);

endmodule

`default_nettype wire

// >>> sim/cpu_core_model.sv
// CPU core stand-in: instruction boundaries, stack pushes and returns.
// Assumes one clock shared with the controller; PC and flags are fixed.
`timescale 1ns/1ps
`default_nettype none

module cpu_core_model
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic run,
    input wire logic [3:0] gap,
    input wire logic do_return,
    input wire logic busy,
    input wire logic push_strobe,
    input wire logic [7:0] push_data,
    input wire logic sp_dec3,
    input wire logic vector_load,
    output logic instr_boundary,
    output logic [15:0] cpu_pc,
    output logic [6:0] cpu_flags,
    output logic return_irq,
    output logic restored_imf,
    output logic [23:0] stacked,
    output logic [7:0] sp,
    output logic [5:0] acc_clks
);
    logic [3:0] wait_cnt;
    logic [5:0] busy_cnt;

    assign cpu_pc = 16'hA5C3;
    assign cpu_flags = 7'h5A;

    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            instr_boundary <= 1'b0;
            return_irq <= 1'b0;
            restored_imf <= 1'b0;
            stacked <= 24'h000000;
            sp <= 8'hFF;
            acc_clks <= 6'h00;
            wait_cnt <= 4'h0;
            busy_cnt <= 6'h00;
        end
        else
        begin
            instr_boundary <= 1'b0;
            return_irq <= 1'b0;
            // Meaningless outside a return, so it keeps moving
            restored_imf <= ~restored_imf;
            // No boundary while acceptance runs
            if (run && !busy && !instr_boundary && !return_irq && !do_return)
            begin
                wait_cnt <= wait_cnt + 4'h1;
                if (wait_cnt >= gap)
                begin
                    instr_boundary <= 1'b1;
                    wait_cnt <= 4'h0;
                end
            end
            if (do_return && !busy)
            begin
                return_irq <= 1'b1;
                restored_imf <= stacked[16];
            end
            if (push_strobe)
                stacked <= {stacked[15:0], push_data};
            if (sp_dec3)
                sp <= sp - 8'h03;
            busy_cnt <= busy ? busy_cnt + 6'h01 : 6'h00;
            if (vector_load)
                acc_clks <= busy_cnt + 6'h01;
        end
    end
endmodule

`default_nettype wire

// >>> sim/prioritized_interrupt_latch_controller_tb.sv
// Self-checking bench for the interrupt latch controller.
// Assumes the CPU stand-in model; stimulus moves on rising edges.
`timescale 1ns/1ps
`default_nettype none

module prioritized_interrupt_latch_controller_tb
    import irq_ctrl_pkg::*;
;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    sfr_req_t sfr = '0;
    logic [23:2] src_req = '0;
    logic software_trap = 1'b0;
    logic illegal_opcode_trap = 1'b0;
    logic ext_zero_pin_enable = 1'b0;
    logic trap_action_select = 1'b1;
    logic watchdog_action_select = 1'b1;
    logic run = 1'b0;
    logic do_return = 1'b0;
    logic [3:0] gap = 4'h0;
    logic instr_boundary, return_irq, restored_imf, irq_pending, busy;
    logic push_strobe, sp_dec3, vector_load, master_irq_enable_flag;
    logic [15:0] cpu_pc, vector;
    logic [6:0] cpu_flags;
    logic [7:0] sfr_rdata, push_data, sp;
    logic [4:0] accepted_source;
    logic [23:0] stacked;
    logic [5:0] acc_clks;
    int failures = 0;
    int compares = 0;
    int cycles = 0;

    always #10 clk = ~clk;

    irq_latch_ctrl u_dut (.clk(clk), .rst_b(rst_b), .sfr(sfr), .sfr_rdata(sfr_rdata),
        .src_req(src_req), .software_trap(software_trap),
        .illegal_opcode_trap(illegal_opcode_trap), .ext_zero_pin_enable(ext_zero_pin_enable),
        .trap_action_select(trap_action_select),
        .watchdog_action_select(watchdog_action_select), .instr_boundary(instr_boundary),
        .cpu_pc(cpu_pc), .cpu_flags(cpu_flags), .return_irq(return_irq),
        .restored_imf(restored_imf), .irq_pending(irq_pending), .busy(busy),
        .push_strobe(push_strobe), .push_data(push_data), .sp_dec3(sp_dec3),
        .vector_load(vector_load), .vector(vector), .accepted_source(accepted_source),
        .master_irq_enable_flag(master_irq_enable_flag));

    cpu_core_model u_cpu (.clk(clk), .rst_b(rst_b), .run(run), .gap(gap),
        .do_return(do_return), .busy(busy), .push_strobe(push_strobe),
        .push_data(push_data), .sp_dec3(sp_dec3), .vector_load(vector_load),
        .instr_boundary(instr_boundary), .cpu_pc(cpu_pc), .cpu_flags(cpu_flags),
        .return_irq(return_irq), .restored_imf(restored_imf), .stacked(stacked),
        .sp(sp), .acc_clks(acc_clks));

    // ----
    // Shared tasks
    // ----
    task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
        compares++;
        if (got !== exp)
        begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        sfr <= '{1'b1, 1'b0, a, d};
        @(posedge clk);
        sfr <= '0;
    endtask

    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        @(posedge clk);
        sfr <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge clk);
        sfr <= '0;
        #1 chk($sformatf("read %h", a), e, sfr_rdata);
    endtask

    task automatic rd_il(input logic [23:2] e);
        rd(ADDR_LATCH_LOW, {e[7:2], 2'b00});
        rd(ADDR_LATCH_HIGH, e[15:8]);
        rd(ADDR_LATCH_EXT, e[23:16]);
    endtask

    // Master goes up last, never together with the enables
    task automatic en(input logic [23:0] m);
        wr(ADDR_ENABLE_LOW, 8'h00);
        wr(ADDR_ENABLE_HIGH, m[15:8]);
        wr(ADDR_ENABLE_EXT, m[23:16]);
        wr(ADDR_ENABLE_LOW, {m[7:4], 4'h0});
        if (m[0])
            wr(ADDR_ENABLE_LOW, {m[7:4], 4'h1});
    endtask

    task automatic req(input logic [23:2] r);
        @(posedge clk);
        src_req <= r;
        @(posedge clk);
        src_req <= '0;
    endtask

    task automatic quiet();
        repeat (8) @(posedge clk);
        #1 chk("irq_pending", 1'b0, irq_pending);
    endtask

    task automatic acc(input logic [15:0] v, input logic [4:0] s, input logic m);
        int n;
        logic [7:0] sp0;
        n = 0;
        sp0 = sp;
        while (vector_load !== 1'b1 && n < 200)
        begin
            @(negedge clk);
            n++;
        end
        chk("vector", v, vector);
        chk("accepted_source", s, accepted_source);
        @(posedge clk);
        #1 chk("accept clocks", ACCEPT_CLKS, acc_clks);
        chk("stacked", {7'h5A, m, 16'hA5C3}, stacked);
        chk("sp", sp0 - 8'h03, sp);
        chk("master", 1'b0, master_irq_enable_flag);
    endtask

    // ----
    // Scenarios
    // ----
    task automatic t_reset();
        rd_il(22'h000000);
        rd(ADDR_ENABLE_LOW, 8'h00);
        rd(ADDR_ENABLE_HIGH, 8'h00);
        rd(ADDR_ENABLE_EXT, 8'h00);
        rd(16'h0030, 8'h00);
        $display("test reset done");
    endtask

    task automatic t_access();
        req(22'h3FFFFF);
        rd_il(22'h3FFFFC);
        wr(ADDR_LATCH_LOW, 8'hDF);
        wr(ADDR_LATCH_HIGH, 8'h00);
        wr(ADDR_LATCH_EXT, 8'hFE);
        wr(ADDR_LATCH_LOW, 8'hFF);
        rd_il(22'h3F8034);
        wr(ADDR_LATCH_LOW, 8'h0C);
        wr(ADDR_LATCH_EXT, 8'h00);
        rd_il(22'h000000);
        $display("test access done");
    endtask

    task automatic t_mask();
        en(24'h000011);
        req(22'h000004);
        quiet();
        @(posedge clk);
        ext_zero_pin_enable <= 1'b1;
        acc(VEC_BANK0_TOP, 5'h04, 1'b1);
        en(24'h000080);
        req(22'h000020);
        quiet();
        en(24'h000001);
        quiet();
        rd_il(22'h000020);
        en(24'h000081);
        acc(16'hFFF0, 5'h07, 1'b1);
        $display("test masking done");
    endtask

    // Odd sources meet a slow core, even ones a prompt one
    task automatic t_vectors();
        for (int i = 4; i < 24; i++)
        begin
            gap <= i[0] ? 4'h5 : 4'h0;
            en((24'h000001 << i) | 24'h000001);
            req(22'h000001 << (i - 2));
            acc((i < 16) ? VEC_BANK0_TOP - 16'(2 * (i - 4)) :
                VEC_BANK1_TOP - 16'(2 * (i - 16)), 5'(i), 1'b1);
            rd_il(22'h000000);
        end
        gap <= 4'h0;
        $display("test vectors done");
    endtask

    task automatic t_prio();
        en(24'h100240);
        req(22'h040090);
        en(24'h100241);
        acc(16'hFFF2, 5'h06, 1'b1);
        en(24'h100241);
        acc(16'hFFEC, 5'h09, 1'b1);
        en(24'h100241);
        acc(16'hFFB6, 5'h14, 1'b1);
        $display("test priority done");
    endtask

    task automatic trap_go(input logic illegal);
        @(posedge clk);
        software_trap <= !illegal;
        illegal_opcode_trap <= illegal;
        for (int n = 0; n < 20 && busy !== 1'b1; n++)
            @(posedge clk);
        software_trap <= 1'b0;
        illegal_opcode_trap <= 1'b0;
    endtask

    task automatic t_nonmask();
        @(posedge clk);
        trap_action_select <= 1'b0;
        watchdog_action_select <= 1'b0;
        src_req <= 22'h000003;
        trap_go(1'b0);
        src_req <= '0;
        acc(VEC_TRAP, 5'h01, 1'b0);
        acc(VEC_ADDR_TRAP, 5'h02, 1'b0);
        acc(VEC_WATCHDOG, 5'h03, 1'b0);
        trap_go(1'b1);
        acc(VEC_TRAP, 5'h01, 1'b0);
        $display("test non-maskable done");
    endtask

    task automatic t_return();
        en(24'h000081);
        req(22'h000020);
        acc(16'hFFF0, 5'h07, 1'b1);
        @(posedge clk);
        do_return <= 1'b1;
        @(posedge clk);
        do_return <= 1'b0;
        repeat (3) @(posedge clk);
        #1 chk("master", 1'b1, master_irq_enable_flag);
        $display("test return done");
    endtask

    task automatic give_verdict();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Whole run needs under two thousand cycles
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            failures++;
            give_verdict();
        end
    end

    initial
    begin
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        t_reset();
        t_access();
        @(posedge clk);
        run <= 1'b1;
        t_mask();
        t_vectors();
        t_prio();
        t_nonmask();
        t_return();
        give_verdict();
    end
endmodule

`default_nettype wire
